/* logic/tpc_top.sv */
`timescale 1ns/10ps
// Timer subsystem: 16-bit five-channel timer plus two 8-bit timers and IR gating.
module tpc_top
   import tpc_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic SYS_RST,
   // Main timer configuration.
   input wire logic MAIN_EN,
   input wire logic [TPC_PS_SEL_W-1:0] MAIN_PS_SEL,
   input wire logic [TPC_MAIN_W-1:0] MAIN_PERIOD,
   input wire logic [TPC_CH_NUM-1:0][TPC_MAIN_W-1:0] CH_CMP,
   input wire logic [TPC_CH_NUM-1:0] CH_CAPT_MODE,
   input wire logic IR_MODE,
   // Small timer configuration.
   input wire logic [TPC_SMALL_NUM-1:0] S_EN,
   input wire logic [TPC_SMALL_NUM-1:0][TPC_PS_SEL_W-1:0] S_PS_SEL,
   input wire logic [TPC_SMALL_NUM-1:0][TPC_SMALL_W-1:0] S_PERIOD,
   input wire logic [TPC_SMALL_NUM-1:0][TPC_SMALL_W-1:0] S_CMP,
   // Pins.
   input wire logic [TPC_CH_NUM-1:0] CAP_PIN,
   output logic [TPC_CH_NUM-1:0] CH_PWM,
   output logic IR_OUT,
   output logic [TPC_SMALL_NUM-1:0] S_PWM,
   // Results and DMA triggers.
   output logic [TPC_MAIN_W-1:0] MAIN_CNT,
   output logic [TPC_CH_NUM-1:0][TPC_MAIN_W-1:0] CAP_VAL,
   output logic MAIN_DMA_TRIG,
   output logic [TPC_CH_NUM-1:0] CH_DMA_TRIG,
   output logic [TPC_SMALL_NUM-1:0] S_DMA_TRIG
);
   logic [TPC_PS_CNT_W-1:0] prediv_reg;
   logic [TPC_PS_CNT_W-1:0] ps_limit;
   logic ps_tick;
   logic main_tick;
   logic [TPC_MAIN_W-1:0] cnt_reg;
   logic [TPC_MAIN_W-1:0] cnt_next;
   logic [TPC_CH_NUM-1:0] pwm_reg;
   logic [TPC_CH_NUM-1:0] cap_meta_reg;
   logic [TPC_CH_NUM-1:0] cap_sync_reg;
   logic [TPC_CH_NUM-1:0] cap_prev_reg;
   logic [TPC_CH_NUM-1:0] cap_edge;
   logic [TPC_CH_NUM-1:0][TPC_MAIN_W-1:0] cap_reg;
   logic [TPC_CH_NUM-1:0] ch_trig_reg;
   logic main_trig_reg;
   logic ir_reg;
   logic [TPC_SMALL_NUM-1:0] s_evt;
   logic [TPC_SMALL_NUM-1:0] s_pwm;

   // Two small timers, each through its own interface.
   genvar gi;
   generate
      for (gi = 0; gi < TPC_SMALL_NUM; gi++) begin : g_small
         tpc_tmr_if #(.W(TPC_SMALL_W)) tif ();
         tpc_small_timer #(.W(TPC_SMALL_W)) u_tmr (
            .clk(CLK),
            .rst(SYS_RST),
            .en(S_EN[gi]),
            .ps_sel(S_PS_SEL[gi]),
            .period(S_PERIOD[gi]),
            .cmp(S_CMP[gi]),
            .tif(tif.src)
         );
         assign s_evt[gi] = tif.period_evt;
         assign s_pwm[gi] = tif.pwm;
         // A period event always comes with a count that has just wrapped to zero.
         small_evt_a: assert property (@(posedge CLK) disable iff (SYS_RST)
            tif.period_evt |-> tif.cnt == '0)
            else $error("small timer event without a wrap");
      end
   endgenerate

   // Main prescaler; in IR mode the carrier timer's period event is the tick instead.
   assign ps_limit = TPC_PS_CNT_W'((1 << MAIN_PS_SEL) - 1);
   assign ps_tick = MAIN_EN && (prediv_reg == ps_limit);
   assign main_tick = IR_MODE ? (MAIN_EN && s_evt[TPC_IR_SMALL]) : ps_tick;
   assign cnt_next = (cnt_reg == MAIN_PERIOD) ? TPC_MAIN_RST : TPC_MAIN_W'(cnt_reg + 1'b1);

   // Prescaler restarts while the timer is stopped, so the first tick comes a full division after enable.
   // It keeps running in IR mode, where its tick is simply ignored.
   always_ff @(posedge CLK) begin
      if (SYS_RST || !MAIN_EN || ps_tick) begin
         prediv_reg <= TPC_PS_ZERO;
      end else begin
         prediv_reg <= prediv_reg + 1'b1;
      end
   end

   // Main 16-bit counter.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cnt_reg <= TPC_MAIN_RST;
      end else if (main_tick) begin
         cnt_reg <= cnt_next;
      end
   end

   // Channel PWM; a channel in capture mode keeps its output low.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pwm_reg <= '0;
      end else begin
         for (int i = 0; i < TPC_CH_NUM; i++) begin
            if (CH_CAPT_MODE[i]) begin
               pwm_reg[i] <= 1'b0;
            end else if (main_tick) begin
               pwm_reg[i] <= (cnt_next < CH_CMP[i]);
            end
         end
      end
   end

   // Capture pins are asynchronous, so two flops precede the edge detector.
   // A pulse shorter than one clock period may be missed entirely.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cap_meta_reg <= '0;
         cap_sync_reg <= '0;
         cap_prev_reg <= '0;
      end else begin
         cap_meta_reg <= CAP_PIN;
         cap_sync_reg <= cap_meta_reg;
         cap_prev_reg <= cap_sync_reg;
      end
   end

   // Rising edges only; the two-flop delay means the stamp lags the pin by up to three cycles.
   assign cap_edge = cap_sync_reg & ~cap_prev_reg & CH_CAPT_MODE;

   // Each capture register keeps its stamp until the next accepted edge.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cap_reg <= '0;
      end else begin
         for (int i = 0; i < TPC_CH_NUM; i++) begin
            if (cap_edge[i]) begin
               cap_reg[i] <= cnt_reg;
            end
         end
      end
   end

   // DMA triggers: capture on capture channels, compare match on PWM channels.
   // A compare value above the period never matches, so that channel never triggers.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ch_trig_reg <= '0;
         main_trig_reg <= 1'b0;
      end else begin
         for (int i = 0; i < TPC_CH_NUM; i++) begin
            ch_trig_reg[i] <= CH_CAPT_MODE[i] ? cap_edge[i] : (main_tick && cnt_next == CH_CMP[i]);
         end
         main_trig_reg <= main_tick && (cnt_reg == MAIN_PERIOD);
      end
   end

   // IR output gates the carrier with the envelope from channel 0.
   // Only channel 0 and the first small timer take part; the other channels keep plain PWM.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ir_reg <= 1'b0;
      end else begin
         ir_reg <= IR_MODE && pwm_reg[TPC_IR_CH] && s_pwm[TPC_IR_SMALL];
      end
   end

   // Every output is taken straight from a register.
   assign CH_PWM = pwm_reg;
   assign IR_OUT = ir_reg;
   assign S_PWM = s_pwm;
   assign MAIN_CNT = cnt_reg;
   assign CAP_VAL = cap_reg;
   assign MAIN_DMA_TRIG = main_trig_reg;
   assign CH_DMA_TRIG = ch_trig_reg;
   assign S_DMA_TRIG = s_evt;

   // Main counter wraps to zero after a period match.
   main_wrap_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      main_tick && cnt_reg == MAIN_PERIOD |=> cnt_reg == TPC_MAIN_RST && MAIN_DMA_TRIG)
      else $error("main counter did not wrap at period");
   // Main counter increments by one below the period.
   main_count_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      main_tick && cnt_reg != MAIN_PERIOD |=> cnt_reg == TPC_MAIN_W'($past(cnt_reg) + 1'b1))
      else $error("main counter did not increment");
   // In IR mode the counter only moves on a carrier period event.
   ir_tick_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      IR_MODE && !s_evt[TPC_IR_SMALL] |=> $stable(cnt_reg))
      else $error("main counter moved without carrier period in IR mode");
   // IR output is the AND of envelope and carrier one cycle later.
   ir_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      1'b1 |=> IR_OUT == ($past(IR_MODE) && $past(pwm_reg[TPC_IR_CH]) && $past(s_pwm[TPC_IR_SMALL])))
      else $error("IR output not carrier-gated");
   // A synchronised rising edge stamps the counter and raises the DMA trigger together.
   cap_stamp_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      cap_edge[0] |=> CAP_VAL[0] == $past(cnt_reg) && CH_DMA_TRIG[0])
      else $error("capture did not stamp counter");
   // A capture channel never drives PWM.
   cap_quiet_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      CH_CAPT_MODE[1] ##1 CH_CAPT_MODE[1] |-> !CH_PWM[1])
      else $error("capture channel drove PWM");
   // Channel PWM follows its compare value on each tick.
   ch_pwm_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      main_tick && !CH_CAPT_MODE[2] |=> CH_PWM[2] == (cnt_reg < $past(CH_CMP[2])))
      else $error("channel PWM level wrong");
   // Period DMA trigger is a single-cycle pulse, except at period zero with the raw clock.
   trig_pulse_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      MAIN_DMA_TRIG && MAIN_PERIOD != TPC_MAIN_RST |=> !MAIN_DMA_TRIG)
      else $error("period trigger longer than one cycle");
   // A pin edge on a PWM channel leaves its capture value alone.
   cap_ignore_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !CH_CAPT_MODE[3] |=> $stable(CAP_VAL[3]))
      else $error("PWM channel took a capture");
   // With IR mode off the modulated output stays low.
   ir_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      !IR_MODE |=> !IR_OUT)
      else $error("IR output active outside IR mode");

   // Cover points for the main scenarios.
   main_wrap_c: cover property (@(posedge CLK) disable iff (SYS_RST) MAIN_DMA_TRIG);
   ir_burst_c: cover property (@(posedge CLK) disable iff (SYS_RST) IR_MODE && IR_OUT ##1 !IR_OUT);
   capture_c: cover property (@(posedge CLK) disable iff (SYS_RST) cap_edge[0]);
   small_pwm_c: cover property (@(posedge CLK) disable iff (SYS_RST) S_PWM[1] ##1 !S_PWM[1]);
endmodule : tpc_top

/* logic/tpc_pkg.sv */
// Functional notes
// - Main counter is 16 bits, prescaled, counts up to a 16-bit period.
// - Main timer has five channels, each with its own 16-bit compare value.
// - Each main channel either drives PWM or captures the counter on an input edge.
// - In IR mode the main counter advances once per first small timer period.
// - In IR mode the IR output is main channel 0 AND first small timer output.
// - Two small timers: 8-bit counter, programmable prescaler, 8-bit period.
// - Each small timer has one 8-bit compare channel driving a PWM output.
// - Timer events raise one-cycle DMA trigger pulses, except a zero period at the undivided clock.
package tpc_pkg;
   localparam int unsigned TPC_CH_NUM = 5;
   localparam int unsigned TPC_MAIN_W = 16;
   localparam int unsigned TPC_SMALL_W = 8;
   localparam int unsigned TPC_SMALL_NUM = 2;
   localparam int unsigned TPC_PS_SEL_W = 3;
   localparam int unsigned TPC_PS_CNT_W = 8;
   localparam logic [7:0] TPC_PS_ZERO = 8'h00;
   localparam logic [15:0] TPC_MAIN_RST = 16'h0000;
   localparam int unsigned TPC_IR_CH = 0;
   localparam int unsigned TPC_IR_SMALL = 0;
endpackage : tpc_pkg

/* logic/tpc_tmr_if.sv */
`timescale 1ns/10ps
// Signals that one timer hands to the logic around it.
interface tpc_tmr_if #(parameter int unsigned W = 8);
   logic period_evt;
   logic pwm;
   logic [W-1:0] cnt;
   modport src (output period_evt, output pwm, output cnt);
   modport dst (input period_evt, input pwm, input cnt);
endinterface : tpc_tmr_if

/* logic/tpc_small_timer.sv */
`timescale 1ns/10ps
// Prescaled up-counter with one compare channel driving PWM.
module tpc_small_timer
   import tpc_pkg::*;
#(
   parameter int unsigned W = TPC_SMALL_W
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Configuration.
   input wire logic en,
   input wire logic [TPC_PS_SEL_W-1:0] ps_sel,
   input wire logic [W-1:0] period,
   input wire logic [W-1:0] cmp,
   // Results.
   tpc_tmr_if.src tif
);
   logic [TPC_PS_CNT_W-1:0] prediv_reg;
   logic [TPC_PS_CNT_W-1:0] ps_limit;
   logic tick;
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic pwm_reg;
   logic evt_reg;

   // Divide by a power of two; zero selects the raw clock.
   assign ps_limit = TPC_PS_CNT_W'((1 << ps_sel) - 1);
   assign tick = en && (prediv_reg == ps_limit);
   assign cnt_next = (cnt_reg == period) ? '0 : W'(cnt_reg + 1'b1);

   // Prescaler restarts whenever the timer is stopped, so a start is aligned.
   always_ff @(posedge clk) begin
      if (rst || !en || tick) begin
         prediv_reg <= TPC_PS_ZERO;
      end else begin
         prediv_reg <= prediv_reg + 1'b1;
      end
   end

   // Counter.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else if (tick) begin
         cnt_reg <= cnt_next;
      end
   end

   // PWM is high while the count is below compare; a zero compare holds it low.
   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_reg <= 1'b0;
      end else if (tick) begin
         pwm_reg <= (cnt_next < cmp);
      end
   end

   // Period event pulses in the same cycle that the count wraps to zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         evt_reg <= 1'b0;
      end else begin
         evt_reg <= tick && (cnt_reg == period);
      end
   end

   assign tif.period_evt = evt_reg;
   assign tif.pwm = pwm_reg;
   assign tif.cnt = cnt_reg;

   // Wrap to zero after a period match.
   small_wrap_a: assert property (@(posedge clk) disable iff (rst)
      tick && cnt_reg == period |=> cnt_reg == '0 && evt_reg)
      else $error("small timer did not wrap at period");
   // Plain increment below period.
   small_count_a: assert property (@(posedge clk) disable iff (rst)
      tick && cnt_reg != period |=> cnt_reg == W'($past(cnt_reg) + 1'b1))
      else $error("small timer did not increment");
   // Counter holds between ticks.
   small_hold_a: assert property (@(posedge clk) disable iff (rst)
      !tick |=> $stable(cnt_reg) && $stable(pwm_reg))
      else $error("small timer moved without a tick");
   // PWM follows the compare relation of the new count.
   small_pwm_a: assert property (@(posedge clk) disable iff (rst)
      tick |=> pwm_reg == (cnt_reg < $past(cmp)))
      else $error("small PWM level wrong");
   small_wrap_c: cover property (@(posedge clk) disable iff (rst) evt_reg ##1 !evt_reg);
endmodule : tpc_small_timer

/* test/tpc_pin_model.sv */
`timescale 1ns/10ps
// Stands in for the external capture sources wired to the channel pins.
module tpc_pin_model
   import tpc_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Requests and pins.
   input wire logic [TPC_CH_NUM-1:0] fire,
   output logic [TPC_CH_NUM-1:0] pins
);
   logic [1:0] hold_reg [TPC_CH_NUM];
   initial begin
      pins = '0;
      hold_reg = '{default: 2'h0};
   end
   // A request holds its pin high for three cycles, longer than the synchroniser needs.
   always @(posedge clk) begin
      for (int i = 0; i < TPC_CH_NUM; i++) begin
         hold_reg[i] <= fire[i] ? 2'h3 : (hold_reg[i] != 2'h0 ? hold_reg[i] - 2'h1 : 2'h0);
         pins[i] <= fire[i] || hold_reg[i] > 2'h1;
      end
   end
endmodule : tpc_pin_model

/* test/timer_pwm_capture_ir_modulator_tb_top.sv */
`timescale 1ns/10ps
// Self-checking bench for the timer subsystem.
module timer_pwm_capture_ir_modulator_tb_top
   import tpc_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic main_en = 1'b0;
   logic ir_mode = 1'b0;
   logic [2:0] main_ps = 3'h0;
   logic [15:0] main_period = 16'h0000;
   logic [TPC_CH_NUM-1:0][15:0] ch_cmp = '0;
   logic [TPC_CH_NUM-1:0] capt = '0;
   logic [TPC_CH_NUM-1:0] fire = '0;
   logic [TPC_CH_NUM-1:0] pins;
   logic [1:0] s_en = 2'h0;
   logic [1:0][2:0] s_ps = '0;
   logic [1:0][7:0] s_period = '0;
   logic [1:0][7:0] s_cmp = '0;
   logic [TPC_CH_NUM-1:0] ch_pwm, ch_trig;
   logic [TPC_CH_NUM-1:0][15:0] cap_val;
   logic [1:0] s_pwm, s_trig;
   logic [15:0] main_cnt;
   logic ir_out, main_trig;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   tpc_top tpc_top_inst (.CLK(clk), .SYS_RST(sys_rst), .MAIN_EN(main_en), .MAIN_PS_SEL(main_ps),
      .MAIN_PERIOD(main_period), .CH_CMP(ch_cmp), .CH_CAPT_MODE(capt), .IR_MODE(ir_mode), .S_EN(s_en),
      .S_PS_SEL(s_ps), .S_PERIOD(s_period), .S_CMP(s_cmp), .CAP_PIN(pins), .CH_PWM(ch_pwm),
      .IR_OUT(ir_out), .S_PWM(s_pwm), .MAIN_CNT(main_cnt), .CAP_VAL(cap_val),
      .MAIN_DMA_TRIG(main_trig), .CH_DMA_TRIG(ch_trig), .S_DMA_TRIG(s_trig));
   tpc_pin_model tpc_pin_model_inst (.clk(clk), .fire(fire), .pins(pins));
   // Clock of 125 MHz.
   always #4 clk = ~clk;
   // A hang ends the run here; the whole sequence needs under two hundred cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Every scenario starts from reset with all units idle.
   task automatic do_reset(input int n);
      @(posedge clk);
      sys_rst <= 1'b1;
      main_en <= 1'b0;
      ir_mode <= 1'b0;
      main_ps <= 3'h0;
      ch_cmp <= '0;
      capt <= '0;
      s_en <= 2'h0;
      s_ps <= '0;
      repeat (n) @(posedge clk);
      sys_rst <= 1'b0;
   endtask : do_reset
   // Period 2, channel i compares at i: counts, PWM levels and triggers per tick.
   task automatic walk_test();
      logic [15:0] c;
      logic [TPC_CH_NUM-1:0] pv, tv;
      do_reset(2);
      main_period <= 16'h0002;
      ch_cmp <= {16'h0004, 16'h0003, 16'h0002, 16'h0001, 16'h0000};
      main_en <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         #1;
         c = 16'((k + 1) % 3);
         for (int i = 0; i < TPC_CH_NUM; i++) begin
            pv[i] = c < i;
            tv[i] = c == i;
         end
         check("main count", main_cnt, c);
         check("channel pwm", 16'(ch_pwm), 16'(pv));
         check("channel trigger", 16'(ch_trig), 16'(tv));
         check("period trigger", 16'(main_trig), 16'(k == 2));
      end
   endtask : walk_test
   // Divide by four: first tick on the fourth edge after enable.
   task automatic prescale_test();
      do_reset(2);
      main_period <= 16'h0064;
      main_ps <= 3'h2;
      main_en <= 1'b1;
      repeat (7) @(posedge clk);
      #1;
      check("prescaled count", main_cnt, 16'h0001);
      @(posedge clk);
      #1;
      check("prescaled count", main_cnt, 16'h0002);
   endtask : prescale_test
   // Counter frozen at 5; pin edges on capture channels 0 and 2 and on PWM channel 3.
   task automatic capture_test();
      do_reset(2);
      main_period <= 16'h0064;
      ch_cmp <= {16'h0000, 16'h0000, 16'h0010, 16'h0010, 16'h0000};
      capt <= 5'b00111;
      main_en <= 1'b1;
      repeat (5) @(posedge clk);
      main_en <= 1'b0;
      fire <= 5'b01101;
      @(posedge clk);
      fire <= 5'h00;
      for (int k = 0; k < 20 && ch_trig[2] !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      check("capture trigger", 16'(ch_trig[2]), 16'h0001);
      check("captured value", cap_val[2], 16'h0005);
      check("captured value ch0", cap_val[0], 16'h0005);
      check("idle capture channel", cap_val[1], 16'h0000);
      check("pwm channel not captured", cap_val[3], 16'h0000);
      check("capture channel pwm", 16'(ch_pwm[2:0]), 16'h0000);
      repeat (4) begin
         @(posedge clk);
         #1;
         check("falling edge ignored", 16'(ch_trig), 16'h0000);
      end
   endtask : capture_test
   // Both small timers, period 3; timer 1 divided by two.
   task automatic small_test();
      logic [15:0] hi0, hi1, tr0, tr1;
      do_reset(2);
      s_period <= {8'h03, 8'h03};
      s_cmp <= {8'h01, 8'h02};
      s_ps <= {3'h1, 3'h0};
      s_en <= 2'h3;
      repeat (4) @(posedge clk);
      {hi0, hi1, tr0, tr1} = '0;
      repeat (16) begin
         @(posedge clk);
         #1;
         hi0 += 16'(s_pwm[0]);
         hi1 += 16'(s_pwm[1]);
         tr0 += 16'(s_trig[0]);
         tr1 += 16'(s_trig[1]);
      end
      check("small 0 high cycles", hi0, 16'h0008);
      check("small 1 high cycles", hi1, 16'h0004);
      check("small 0 wraps", tr0, 16'h0004);
      check("small 1 wraps", tr1, 16'h0002);
   endtask : small_test
   // Main counter steps once per four-cycle small timer period; output is the gated product.
   task automatic ir_test();
      logic [15:0] c0;
      logic [15:0] hi;
      logic prev;
      do_reset(2);
      ir_mode <= 1'b1;
      s_period[0] <= 8'h03;
      s_cmp[0] <= 8'h02;
      s_en <= 2'h1;
      main_period <= 16'h0FFF;
      ch_cmp[0] <= 16'h0800;
      main_en <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      c0 = main_cnt;
      hi = 16'h0000;
      prev = ch_pwm[0] & s_pwm[0];
      repeat (40) begin
         @(posedge clk);
         #1;
         check("ir output", 16'(ir_out), 16'(prev));
         hi += 16'(ir_out);
         prev = ch_pwm[0] & s_pwm[0];
      end
      check("ir main advance", main_cnt - c0, 16'h000A);
      check("ir high cycles", hi, 16'h0014);
      check("ir envelope", 16'(ch_pwm[0]), 16'h0001);
   endtask : ir_test
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   // Main sequence.
   initial begin
      do_reset(16);
      walk_test();
      prescale_test();
      capture_test();
      small_test();
      ir_test();
      wrap_up();
   end
endmodule : timer_pwm_capture_ir_modulator_tb_top
